// File: design/line_cycle_energy_and_var_calc.v
// Metering datapath: energy pulse, line-cycle energy, reactive power.
// Assumes sample strobes on aclk and an asynchronous crossing pin.
//
// Design decision made here: the AXI4-Lite slave port.
`default_nettype none
`include "line_cycle_energy_defines.vh"

module line_cycle_energy_and_var_calc #(
    parameter SW = 24,
    parameter ACCW = 49,
    parameter PULSE_BIT = 40,
    parameter PULSE_LEN = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sample_valid,
    input wire [SW-1:0] active_power_in,
    input wire [SW-1:0] voltage_in,
    input wire [SW-1:0] current_shifted_in,
    input wire zero_cross_pin,
    output reg energy_pulse_output_n,
    output reg metering_irq
);

    // Registers
    reg [7:0] waveform_source_select_r;
    reg [7:0] accumulation_mode_config_r;
    reg [7:0] metering_irq_enable_3_r;
    reg [7:0] metering_irq_status_3_r;
    reg [15:0] half_cycle_count_r;
    reg [11:0] reactive_gain_r;
    reg [15:0] reactive_offset_r;
    reg [11:0] active_gain_r;
    reg [7:0] energy_divider_r;
    reg [23:0] line_cycle_energy_result_r;
    reg [23:0] waveform_sample_r;
    reg [ACCW-1:0] energy_acc_r;
    reg [ACCW-1:0] line_acc_r;
    reg [15:0] half_cycles_seen_r;
    reg line_armed_r;
    reg [7:0] div_cnt_r;
    reg [SW+3:0] var_lpf_r;
    reg [SW-1:0] var_out_r;
    reg [SW-1:0] act_gained_r;
    reg [7:0] pulse_cnt_r;
    reg pulse_src_r;
    reg [4:0] wav_div_r;
    reg zc_meta_r, zc_sync_r, zc_prev_r;

    // Write channel latches: address and data accepted independently
    reg aw_have_r, w_have_r;
    reg [7:0] aw_idx_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;

    // Byte address to register index
    function [7:0] addr_to_idx;
        input [31:0] a;
        begin
            addr_to_idx = a[9:2];
        end
    endfunction

    function is_mapped;
        input [7:0] i;
        begin
            case (i)
                `IDX_WAVEFORM_SOURCE_SELECT, `IDX_ACCUMULATION_MODE_CONFIG,
                `IDX_METERING_IRQ_ENABLE_3, `IDX_METERING_IRQ_STATUS_3,
                `IDX_HALF_CYCLE_COUNT, `IDX_REACTIVE_GAIN, `IDX_REACTIVE_OFFSET,
                `IDX_ACTIVE_GAIN, `IDX_ENERGY_DIVIDER, `IDX_LINE_CYCLE_ENERGY_RESULT,
                `IDX_WAVEFORM_SAMPLE, `IDX_ACTIVE_ENERGY: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // Signed gain: x * (1 + g / 4096); same shift for both gains
    function [SW-1:0] apply_gain;
        input [SW-1:0] x;
        input [11:0] g;
        reg signed [SW+12:0] p;
        begin
            p = $signed(x) * $signed(g);
            apply_gain = x + p[SW+`GAIN_SHIFT-1:`GAIN_SHIFT];
        end
    endfunction

    wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    wire [7:0] wr_idx = aw_idx_r;
    wire wr_byte0 = wr_fire && w_strb_r[0];
    wire wr_byte1 = wr_fire && w_strb_r[1];
    wire zc_event = zc_sync_r && !zc_prev_r;

    // Zero crossing pin through two flops, then rising-edge detect
    always @(posedge aclk) begin
        if (!aresetn) begin
            zc_meta_r <= 1'b0;
            zc_sync_r <= 1'b0;
            zc_prev_r <= 1'b0;
        end else begin
            zc_meta_r <= zero_cross_pin;
            zc_sync_r <= zc_meta_r;
            zc_prev_r <= zc_sync_r;
        end
    end

    // Active power after gain, then mode shaping
    wire [SW-1:0] act_g = apply_gain(active_power_in, active_gain_r);
    wire act_neg = act_g[SW-1];
    wire [SW-1:0] act_mag = act_neg ? (~act_g + {{(SW-1){1'b0}}, 1'b1}) : act_g;
    reg [SW-1:0] act_mode;
    always @* begin
        // Positive-only wins when both set: more restrictive
        if (accumulation_mode_config_r[`ACC_POS_BIT])
            act_mode = act_neg ? {SW{1'b0}} : act_g;
        else if (accumulation_mode_config_r[`ACC_ABS_BIT])
            act_mode = act_mag;
        else
            act_mode = act_g;
    end

    // Divider: one sample in N strobes, zero acts as one
    wire [7:0] div_n = (energy_divider_r == 8'h00) ? 8'h01 : energy_divider_r;
    wire div_last = sample_valid && (div_cnt_r + 8'h01 >= div_n);
    wire [SW-1:0] div_in = act_mode;
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_r <= 8'h00;
        end else if (sample_valid) begin
            // Decimation scales energy by 1/N
            if (div_last)
                div_cnt_r <= 8'h00;
            else
                div_cnt_r <= div_cnt_r + 8'h01;
        end
    end
    wire acc_step = div_last;
    wire [ACCW-1:0] acc_add = {{(ACCW-SW){div_in[SW-1]}}, div_in};

    // Both accumulators share acc_add: equal LSB weight
    wire period_end = zc_event && line_armed_r && (half_cycles_seen_r + 16'h0001 >= half_cycle_count_r);
    wire count_write = wr_byte0 && (wr_idx == `IDX_HALF_CYCLE_COUNT);
    always @(posedge aclk) begin
        if (!aresetn) begin
            energy_acc_r <= {ACCW{1'b0}};
            line_acc_r <= {ACCW{1'b0}};
            half_cycles_seen_r <= 16'h0000;
            line_armed_r <= 1'b0;
            line_cycle_energy_result_r <= 24'h000000;
        end else begin
            if (acc_step)
                energy_acc_r <= energy_acc_r + acc_add;
            if (count_write) begin
                line_cycle_energy_result_r <= 24'h000000;
                line_acc_r <= {ACCW{1'b0}};
                half_cycles_seen_r <= 16'h0000;
                line_armed_r <= 1'b0;
            end else if (zc_event && !line_armed_r) begin
                // First crossing after a count write opens a period
                line_armed_r <= 1'b1;
                line_acc_r <= {ACCW{1'b0}};
                half_cycles_seen_r <= 16'h0000;
            end else if (period_end) begin
                // Result overwritten even if unread; new period starts now
                line_cycle_energy_result_r <= line_acc_r[ACCW-1:ACCW-24];
                line_acc_r <= acc_step ? acc_add : {ACCW{1'b0}};
                half_cycles_seen_r <= 16'h0000;
            end else begin
                if (acc_step && line_armed_r)
                    line_acc_r <= line_acc_r + acc_add;
                if (zc_event)
                    half_cycles_seen_r <= half_cycles_seen_r + 16'h0001;
            end
        end
    end

    // Pulse on a toggle of the chosen energy bit while no pulse is running
    always @(posedge aclk) begin
        if (!aresetn) begin
            pulse_src_r <= 1'b0;
            pulse_cnt_r <= 8'h00;
            energy_pulse_output_n <= 1'b1;
        end else begin
            pulse_src_r <= energy_acc_r[PULSE_BIT];
            if (pulse_src_r != energy_acc_r[PULSE_BIT] && pulse_cnt_r == 8'h00)
                pulse_cnt_r <= PULSE_LEN[7:0];
            else if (pulse_cnt_r != 8'h00)
                pulse_cnt_r <= pulse_cnt_r - 8'h01;
            energy_pulse_output_n <= (pulse_cnt_r == 8'h00);
        end
    end

    // Reactive: product, then one-pole low-pass; the active path has none
    wire signed [2*SW-1:0] q_prod = $signed(voltage_in) * $signed(current_shifted_in);
    wire [SW+3:0] q_inst = {{4{q_prod[2*SW-2]}}, q_prod[2*SW-2:SW-1]};
    wire [SW+3:0] lpf_step = $signed(q_inst - var_lpf_r) >>> `LPF_SHIFT;
    wire [SW-1:0] var_filt = var_lpf_r[SW-1:0];
    wire [SW-1:0] var_gained = apply_gain(var_filt, reactive_gain_r);
    // Offset in 1/256 LSB units: arithmetic shift drops the fraction
    wire [SW-1:0] var_ofs = {{(SW-8){reactive_offset_r[15]}}, reactive_offset_r[15:`OFFSET_SHIFT]};
    always @(posedge aclk) begin
        if (!aresetn) begin
            var_lpf_r <= {(SW+4){1'b0}};
            var_out_r <= {SW{1'b0}};
            act_gained_r <= {SW{1'b0}};
        end else if (sample_valid) begin
            var_lpf_r <= var_lpf_r + lpf_step;
            var_out_r <= var_gained + var_ofs;
            act_gained_r <= act_g;
        end
    end

    // Waveform sample at strobe rate divided by 1, 2, 4 or 8
    wire [1:0] wav_rate = waveform_source_select_r[`WAV_RATE_HI:`WAV_RATE_LO];
    wire [4:0] wav_mask = (5'h01 << wav_rate) - 5'h01;
    always @(posedge aclk) begin
        if (!aresetn) begin
            wav_div_r <= 5'h00;
            waveform_sample_r <= 24'h000000;
        end else if (sample_valid) begin
            wav_div_r <= (wav_div_r + 5'h01) & wav_mask;
            if (wav_div_r == 5'h00 && metering_irq_enable_3_r[`IRQ_WAVE_BIT]) begin
                case (waveform_source_select_r[`WAV_SEL_HI:`WAV_SEL_LO])
                    `WAV_SEL_REACTIVE: waveform_sample_r <= var_out_r;
                    `WAV_SEL_ACTIVE: waveform_sample_r <= act_gained_r;
                    default: waveform_sample_r <= waveform_sample_r;
                endcase
            end
        end
    end

    // AXI write path, config registers and sticky status
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_idx_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            waveform_source_select_r <= `RST_BYTE;
            accumulation_mode_config_r <= `RST_BYTE;
            metering_irq_enable_3_r <= `RST_BYTE;
            metering_irq_status_3_r <= `RST_BYTE;
            half_cycle_count_r <= `RST_HALF_CYCLE_COUNT;
            reactive_gain_r <= 12'h000;
            reactive_offset_r <= 16'h0000;
            active_gain_r <= 12'h000;
            energy_divider_r <= `RST_BYTE;
            metering_irq <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_idx_r <= addr_to_idx(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_byte0) begin
                case (wr_idx)
                    `IDX_WAVEFORM_SOURCE_SELECT: waveform_source_select_r <= w_data_r[7:0];
                    `IDX_ACCUMULATION_MODE_CONFIG: accumulation_mode_config_r <= w_data_r[7:0];
                    `IDX_METERING_IRQ_ENABLE_3: metering_irq_enable_3_r <= w_data_r[7:0];
                    `IDX_ENERGY_DIVIDER: energy_divider_r <= w_data_r[7:0];
                    `IDX_HALF_CYCLE_COUNT: half_cycle_count_r[7:0] <= w_data_r[7:0];
                    `IDX_REACTIVE_GAIN: reactive_gain_r[7:0] <= w_data_r[7:0];
                    `IDX_REACTIVE_OFFSET: reactive_offset_r[7:0] <= w_data_r[7:0];
                    `IDX_ACTIVE_GAIN: active_gain_r[7:0] <= w_data_r[7:0];
                    default: ;
                endcase
            end
            if (wr_byte1) begin
                case (wr_idx)
                    `IDX_HALF_CYCLE_COUNT: half_cycle_count_r[15:8] <= w_data_r[15:8];
                    `IDX_REACTIVE_GAIN: reactive_gain_r[11:8] <= w_data_r[11:8];
                    `IDX_REACTIVE_OFFSET: reactive_offset_r[15:8] <= w_data_r[15:8];
                    `IDX_ACTIVE_GAIN: active_gain_r[11:8] <= w_data_r[11:8];
                    default: ;
                endcase
            end
            // Status: write one to clear; a period end wins
            if (wr_byte0 && wr_idx == `IDX_METERING_IRQ_STATUS_3)
                metering_irq_status_3_r[`IRQ_CYCLE_END_BIT] <= period_end ||
                    (metering_irq_status_3_r[`IRQ_CYCLE_END_BIT] && !w_data_r[`IRQ_CYCLE_END_BIT]);
            else if (period_end)
                metering_irq_status_3_r[`IRQ_CYCLE_END_BIT] <= 1'b1;
            metering_irq <= metering_irq_status_3_r[`IRQ_CYCLE_END_BIT] &&
                metering_irq_enable_3_r[`IRQ_CYCLE_END_BIT];
        end
    end

    // Read data mux
    reg [31:0] rd_mux;
    always @* begin
        case (addr_to_idx(s_axi_araddr))
            `IDX_WAVEFORM_SOURCE_SELECT: rd_mux = {24'h0, waveform_source_select_r};
            `IDX_ACCUMULATION_MODE_CONFIG: rd_mux = {24'h0, accumulation_mode_config_r};
            `IDX_METERING_IRQ_ENABLE_3: rd_mux = {24'h0, metering_irq_enable_3_r};
            `IDX_METERING_IRQ_STATUS_3: rd_mux = {24'h0, metering_irq_status_3_r};
            `IDX_HALF_CYCLE_COUNT: rd_mux = {16'h0, half_cycle_count_r};
            `IDX_REACTIVE_GAIN: rd_mux = {20'h0, reactive_gain_r};
            `IDX_REACTIVE_OFFSET: rd_mux = {16'h0, reactive_offset_r};
            `IDX_ACTIVE_GAIN: rd_mux = {20'h0, active_gain_r};
            `IDX_ENERGY_DIVIDER: rd_mux = {24'h0, energy_divider_r};
            `IDX_LINE_CYCLE_ENERGY_RESULT: rd_mux = {8'h00, line_cycle_energy_result_r};
            `IDX_WAVEFORM_SAMPLE: rd_mux = {8'h00, waveform_sample_r};
            `IDX_ACTIVE_ENERGY: rd_mux = {8'h00, energy_acc_r[ACCW-1:ACCW-24]};
            default: rd_mux = 32'h0;
        endcase
    end

    // AXI read path: one-cycle arready, data the cycle after
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= is_mapped(addr_to_idx(s_axi_araddr)) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// File: shared/line_cycle_energy_defines.vh
// Register map, field positions and constants of the metering block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef LINE_CYCLE_ENERGY_DEFINES_VH
`define LINE_CYCLE_ENERGY_DEFINES_VH

// Register indices; byte address is index times four
`define IDX_WAVEFORM_SOURCE_SELECT 8'h0d
`define IDX_ACCUMULATION_MODE_CONFIG 8'h0f
`define IDX_METERING_IRQ_ENABLE_3 8'hdb
`define IDX_METERING_IRQ_STATUS_3 8'hde
`define IDX_HALF_CYCLE_COUNT 8'he0
`define IDX_REACTIVE_GAIN 8'he1
`define IDX_REACTIVE_OFFSET 8'he2
`define IDX_ACTIVE_GAIN 8'he3
`define IDX_ENERGY_DIVIDER 8'he4
`define IDX_LINE_CYCLE_ENERGY_RESULT 8'he5
`define IDX_WAVEFORM_SAMPLE 8'he6
`define IDX_ACTIVE_ENERGY 8'he7

// Field positions
`define ACC_POS_BIT 0
`define ACC_ABS_BIT 1
`define IRQ_CYCLE_END_BIT 2
`define IRQ_WAVE_BIT 5
`define WAV_SEL_LO 0
`define WAV_SEL_HI 1
`define WAV_RATE_LO 2
`define WAV_RATE_HI 3
`define WAV_SEL_REACTIVE 2'h2
`define WAV_SEL_ACTIVE 2'h1

// Reset values
`define RST_HALF_CYCLE_COUNT 16'hffff
`define RST_BYTE 8'h00

// Scaling
`define GAIN_SHIFT 12
`define OFFSET_SHIFT 8
`define LPF_SHIFT 4

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: tb/line_cycle_energy_monitor.sv
// Port checker: bus handshakes, pulse width, interrupt causes.
// Assumes binding onto the top module; one clock, synchronous reset.
`default_nettype none
module line_cycle_energy_monitor #(
    parameter int PULSE_LEN = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic zero_cross_pin,
    input wire logic energy_pulse_output_n,
    input wire logic metering_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] low_cnt_r;
    logic [4:0] zc_age_r;
    logic [4:0] wr_age_r;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Pulse low time; saturating ages of last crossing and write
    always @(posedge aclk) begin
        if (!aresetn) begin
            low_cnt_r <= 8'h00;
            zc_age_r <= 5'h1f;
            wr_age_r <= 5'h1f;
        end else begin
            low_cnt_r <= energy_pulse_output_n ? 8'h00 : low_cnt_r + 8'h01;
            zc_age_r <= zero_cross_pin ? 5'h00 : (zc_age_r == 5'h1f ? zc_age_r : zc_age_r + 5'h01);
            wr_age_r <= (s_axi_wvalid && s_axi_wready) ? 5'h00 : (wr_age_r == 5'h1f ? wr_age_r : wr_age_r + 5'h01);
        end
    end
    pulse_width_a: assert property ($rose(energy_pulse_output_n) |-> low_cnt_r == PULSE_LEN)
        else $error("pulse width");
    aw_single_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready stuck");
    aw_cause_a: assert property (s_axi_awready |-> s_axi_awvalid)
        else $error("awready without awvalid");
    w_cause_a: assert property (s_axi_wready |-> s_axi_wvalid)
        else $error("wready without wvalid");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer unstable");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    irq_rise_a: assert property ($rose(metering_irq) |-> zc_age_r < 12 || wr_age_r < 12)
        else $error("irq rose without cause");
    irq_fall_a: assert property ($fell(metering_irq) |-> wr_age_r < 12)
        else $error("irq fell without write");
    cover property ($rose(metering_irq));
    cover property ($fell(energy_pulse_output_n));
    cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind line_cycle_energy_and_var_calc line_cycle_energy_monitor #(.PULSE_LEN(PULSE_LEN)) u_monitor (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .zero_cross_pin(zero_cross_pin), .energy_pulse_output_n(energy_pulse_output_n),
    .metering_irq(metering_irq)
);
`default_nettype wire

// File: tb/line_source_model.sv
// Line source: sample strobes, levels and zero crossings.
// Assumes the bench sets the levels; crossings rise once every HALF cycles.
`default_nettype none
module line_source_model #(
    parameter int HALF = 400,
    parameter int SPACING = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [23:0] power_level,
    input wire logic [23:0] volt_level,
    output logic sample_valid,
    output logic [23:0] active_power_in,
    output logic [23:0] voltage_in,
    output logic [23:0] current_shifted_in,
    output logic zero_cross_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned tick_r;
    // Tick paces strobes and crossings
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_r <= 0;
            sample_valid <= 1'b0;
            zero_cross_pin <= 1'b0;
        end else begin
            tick_r <= tick_r + 1;
            sample_valid <= (tick_r % SPACING) == 0;
            zero_cross_pin <= (tick_r % HALF) < (HALF / 2);
        end
    end
    // Data inverted off the strobe to expose mistimed sampling
    assign active_power_in = sample_valid ? power_level : ~power_level;
    assign voltage_in = sample_valid ? volt_level : ~volt_level;
    assign current_shifted_in = sample_valid ? volt_level : ~volt_level;
endmodule
`default_nettype wire

// File: tb/test_line_cycle_energy_and_var_calc.sv
// Bench: registers, line-cycle periods and modes, reactive path.
// Assumes the line source model; expectations follow from test levels.
`default_nettype none
`include "line_cycle_energy_defines.vh"
module test_line_cycle_energy_and_var_calc;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 400;
    localparam int SPACING = 8;
    localparam int EXP_LINE = ((2 * HALF / SPACING) * (1 << 22)) >> 25;
    localparam A_WAV = `IDX_WAVEFORM_SOURCE_SELECT * 4;
    localparam A_ACC = `IDX_ACCUMULATION_MODE_CONFIG * 4;
    localparam A_IEN = `IDX_METERING_IRQ_ENABLE_3 * 4;
    localparam A_STS = `IDX_METERING_IRQ_STATUS_3 * 4;
    localparam A_HCC = `IDX_HALF_CYCLE_COUNT * 4;
    localparam A_GAIN = `IDX_REACTIVE_GAIN * 4;
    localparam A_OFS = `IDX_REACTIVE_OFFSET * 4;
    localparam A_RES = `IDX_LINE_CYCLE_ENERGY_RESULT * 4;
    localparam A_SMP = `IDX_WAVEFORM_SAMPLE * 4;
    logic aclk, aresetn, sample_valid, zero_cross_pin, energy_pulse_output_n, metering_irq;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp;
    logic [23:0] active_power_in, voltage_in, current_shifted_in, power_level, volt_level;
    int err_total, comparisons, cycles, pulses;
    line_cycle_energy_and_var_calc #(.PULSE_BIT(26)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .sample_valid(sample_valid), .active_power_in(active_power_in), .voltage_in(voltage_in),
        .current_shifted_in(current_shifted_in), .zero_cross_pin(zero_cross_pin),
        .energy_pulse_output_n(energy_pulse_output_n), .metering_irq(metering_irq));
    line_source_model #(.HALF(HALF), .SPACING(SPACING)) u_line (
        .aclk(aclk), .aresetn(aresetn), .power_level(power_level), .volt_level(volt_level),
        .sample_valid(sample_valid), .active_power_in(active_power_in), .voltage_in(voltage_in),
        .current_shifted_in(current_shifted_in), .zero_cross_pin(zero_cross_pin));
    // 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // Cycle ceiling cuts a hang short
    always @(posedge aclk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            wrap_up();
        end
    end
    // Count pulse starts
    always @(negedge energy_pulse_output_n) pulses = pulses + 1;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
        end
    endtask
    // Address and data offered together
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic expect_reg(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(d, exp);
        check({30'h0, r}, {30'h0, `RESP_OKAY});
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        while (metering_irq !== 1'b1 && n < 2000) begin
            @(posedge aclk);
            n++;
        end
    endtask
    // Reset values, upper lanes ignored, unmapped place refused
    task automatic t_registers();
        logic [31:0] d;
        logic [1:0] r;
        expect_reg(A_HCC, 32'h0000ffff);
        expect_reg(A_STS, 32'h0);
        axi_write(A_HCC, 32'h1234ffff);
        expect_reg(A_HCC, 32'h0000ffff);
        axi_read(32'h000003fc, d, r);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, `RESP_SLVERR});
        axi_write(32'h000003fc, 32'h1);
        check({30'h0, wr_resp}, {30'h0, `RESP_SLVERR});
    endtask
    // Each accumulation mode, two back-to-back periods
    task automatic t_line();
        int n;
        logic [31:0] res;
        for (int m = 0; m < 4; m++) begin
            power_level <= (m == 0) ? 24'h400000 : 24'hc00000;
            res = (m == 0 || m == 2) ? EXP_LINE : 0;
            axi_write(A_ACC, m);
            axi_write(A_HCC, 32'h2);
            expect_reg(A_RES, 32'h0);
            axi_write(A_STS, 32'h4);
            axi_write(A_IEN, 32'h4);
            pulses = 0;
            wait_irq(n);
            check({31'h0, n < 2000}, 32'h1);
            expect_reg(A_STS, 32'h4);
            expect_reg(A_RES, res);
            check({31'h0, pulses > 0}, {31'h0, res != 0});
            axi_write(A_STS, 32'h4);
            repeat (2) @(posedge aclk);
            check({31'h0, metering_irq}, 32'h0);
            wait_irq(n);
            check({31'h0, n < 2 * HALF + 50}, 32'h1);
            expect_reg(A_RES, res);
            axi_write(A_IEN, 32'h0);
        end
    endtask
    // Offset weight at each rate, then gain of one half
    task automatic t_reactive();
        logic [31:0] a, b;
        logic [1:0] r;
        int diff;
        axi_write(A_IEN, 32'h20);
        axi_write(A_OFS, 32'h100);
        for (int k = 0; k < 4; k++) begin
            axi_write(A_WAV, {28'h0, k[1:0], 2'h2});
            repeat (1000) @(posedge aclk);
            expect_reg(A_SMP, 32'h1);
        end
        axi_write(A_OFS, 32'hff00);
        axi_write(A_WAV, 32'h2);
        repeat (1000) @(posedge aclk);
        axi_read(A_SMP, a, r);
        check({8'h0, a[23:0]}, 32'h00ffffff);
        axi_write(A_OFS, 32'h0);
        volt_level <= 24'h040000;
        repeat (2000) @(posedge aclk);
        axi_read(A_SMP, a, r);
        axi_write(A_GAIN, 32'h800);
        repeat (2000) @(posedge aclk);
        axi_read(A_SMP, b, r);
        diff = $signed(a[23:0]) - 2 * $signed(b[23:0]);
        check({31'h0, a[23:0] != 24'h0}, 32'h1);
        check({31'h0, diff >= -4 && diff <= 4}, 32'h1);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Reset, then the scenarios
    initial begin
        {err_total, comparisons, cycles, pulses} = '0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {power_level, volt_level} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_registers();
        t_line();
        t_reactive();
        wrap_up();
    end
endmodule
`default_nettype wire
